/* File: hw/amploa_top.sv */
`default_nettype none
module amploa_top (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // motion side
  output logic             start_pulse,
  output logic [1:0]       start_axis,
  output logic [31:0]      start_target
);
  localparam int unsigned N = amploa_pkg::NAXIS;

  ////////////////////////////////////////////////////////////////////////
  // per-axis storage, then the shared axis, data, config and status registers
  logic [31:0] vel_r   [N];
  logic [31:0] acc_r   [N];
  logic [15:0] lines_r [N];
  logic [15:0] steps_r [N];
  logic [31:0] tgt_r   [N];
  logic        tgt_rel_r [N];
  logic [31:0] act_r   [N];
  logic [31:0] pos_r   [N];
  logic [1:0]  axis_r;
  logic [31:0] data_r;
  logic [2:0]  cfg_r;
  logic        err_r;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] sat32(input logic [63:0] v, input logic [31:0] lim);
    sat32 = (v > {32'h0000_0000, lim}) ? lim : v[31:0];
  endfunction

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] hi);
    if (v == 16'h0000) begin
      clamp16 = 16'h0001;
    end else if (v > hi) begin
      clamp16 = hi;
    end else begin
      clamp16 = v;
    end
  endfunction

  // relative targets add to where the axis last stopped
  function automatic logic [31:0] dest_of(
    input logic        rel,
    input logic [31:0] pos,
    input logic [31:0] tgt
  );
    if (rel) begin
      dest_of = 32'(pos + tgt);
    end else begin
      dest_of = tgt;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire hit_axis = paddr == amploa_pkg::OFF_CMD_AXIS;
  wire hit_data = paddr == amploa_pkg::OFF_CMD_DATA;
  wire hit_go   = paddr == amploa_pkg::OFF_CMD_GO;
  wire hit_cfg  = paddr == amploa_pkg::OFF_CONFIG;
  wire hit_st   = paddr == amploa_pkg::OFF_STATUS;
  wire hit_rv   = paddr == amploa_pkg::OFF_RD_VEL;
  wire hit_ra   = paddr == amploa_pkg::OFF_RD_ACC;
  wire hit_rs   = paddr == amploa_pkg::OFF_RD_SL;
  wire hit_rt   = paddr == amploa_pkg::OFF_RD_TGT;
  wire hit_rc   = paddr == amploa_pkg::OFF_RD_ACT;
  wire hit_rp   = paddr == amploa_pkg::OFF_RD_POS;
  wire mapped   = hit_axis | hit_data | hit_go | hit_cfg | hit_st | hit_rv | hit_ra | hit_rs
                | hit_rt | hit_rc | hit_rp;
  wire [2:0] cmd = pwdata[2:0];
  wire servo     = cfg_r[amploa_pkg::CFG_SERVO_BIT];
  wire closed    = cfg_r[amploa_pkg::CFG_CLOSED_BIT];
  wire rel_mode  = cfg_r[amploa_pkg::CFG_REL_BIT];
  wire [1:0] ax  = axis_r;

  // data word of rpm and rpsps holds an unsigned 16.16 fixed-point value
  // four counts per line
  wire [17:0] cnt_rev = {lines_r[ax], 2'h0};
  wire [17:0] unit_rev = servo ? cnt_rev : {2'h0, steps_r[ax]};
  wire [63:0] prod    = {32'h0000_0000, data_r} * {46'h0, unit_rev};
  // rpm to units
  // servo: rev/min * cnt/rev * 341us / 60s; stepper: rev/min * steps/rev / 60
  // 60 s per minute and 10^6 us per second fold into one divisor
  wire [63:0] vel_srv = (prod * 64'(amploa_pkg::SAMPLE_US)) / 64'h0000_0000_0393_8700;
  wire [63:0] vel_stp = prod / 64'h0000_0000_0000_003c;
  // the 16.16 fraction is dropped only after the divide to keep resolution
  wire [63:0] vel_raw = (servo ? vel_srv : vel_stp) >> 16;
  // servo accel in counts per sample squared
  // the servo product can pass 64 bits before the divide by 10^12 brings it back
  wire [95:0] acc_wide = {32'h0000_0000, prod} * 96'(amploa_pkg::SAMPLE_US * amploa_pkg::SAMPLE_US);
  wire [95:0] acc_quot = acc_wide / 96'h0000_0000_0000_00e8_d4a5_1000;
  wire [63:0] acc_srv  = acc_quot[63:0];
  // stepper accel in steps per s squared
  wire [63:0] acc_raw = (servo ? acc_srv : prod) >> 16;
  wire [15:0] sl_lines = data_r[amploa_pkg::SL_LINES_LSB +: 16];
  wire [15:0] sl_steps = data_r[15:0];

  // read selection; unmapped offsets read as zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_axis) begin
      rd_mux = {30'h0, axis_r};
    end else if (hit_data) begin
      rd_mux = data_r;
    end else if (hit_cfg) begin
      rd_mux = {29'h0, cfg_r};
    end else if (hit_st) begin
      rd_mux = {31'h0, err_r};
    end else if (hit_rv) begin
      rd_mux = vel_r[ax];
    end else if (hit_ra) begin
      rd_mux = acc_r[ax];
    end else if (hit_rs) begin
      rd_mux = {lines_r[ax], steps_r[ax]};
    end else if (hit_rt) begin
      rd_mux = tgt_r[ax];
    end else if (hit_rc) begin
      rd_mux = act_r[ax];
    end else if (hit_rp) begin
      rd_mux = pos_r[ax];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus answers one cycle after setup, no wait states
  wire setup = psel & ~penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'h0;
    end else begin
      pready <= setup;
    end
  end

  // an unmapped offset gets the same prompt answer, flagged, so the master never waits longer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'h0;
    end else begin
      pslverr <= setup & ~mapped;
    end
  end

  // read data is zero outside a read answer so stale words never linger on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // access phase completes when pready is high; a write lands at that edge only
  wire wdone = wr & pready & mapped;

  // the axis number selects which axis every later command touches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axis_r <= 2'h0;
    end else if (wdone & hit_axis) begin
      axis_r <= pwdata[1:0];
    end
  end

  // operand staged here so the command write carries only its code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= 32'h0000_0000;
    end else if (wdone & hit_data) begin
      data_r <= pwdata;
    end
  end

  // mode bits only change between commands, so each load sees a steady mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= 3'h0;
    end else if (wdone & hit_cfg) begin
      cfg_r <= pwdata[2:0];
    end
  end

  wire sl_reject = wdone & hit_go & (cmd == amploa_pkg::CMD_STEPS_LINES) & ~closed;
  wire err_clr   = wdone & hit_st & pwdata[amploa_pkg::ST_ERR_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 1'h0;
    end else if (sl_reject) begin
      // a new error wins over a clear in the same cycle
      err_r <= 1'h1;
    end else if (err_clr) begin
      err_r <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command execution; per-axis settings by axis number
  wire exec     = wdone & hit_go;
  wire is_rpm   = exec & (cmd == amploa_pkg::CMD_RPM);
  wire is_rpsps = exec & (cmd == amploa_pkg::CMD_RPSPS);
  wire is_sl    = exec & (cmd == amploa_pkg::CMD_STEPS_LINES) & closed;
  wire is_tgt   = exec & (cmd == amploa_pkg::CMD_TARGET);
  wire is_start = exec & (cmd == amploa_pkg::CMD_START);
  wire is_stop  = exec & (cmd == amploa_pkg::CMD_STOP);
  // absolute destination; relative to last stop
  wire [31:0] start_dest = dest_of(tgt_rel_r[ax], pos_r[ax], tgt_r[ax]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        vel_r[i] <= 32'h0000_0000;
      end
    end else if (is_rpm) begin
      vel_r[ax] <= sat32(vel_raw, amploa_pkg::VEL_MAX);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        acc_r[i] <= 32'h0000_0000;
      end
    end else if (is_rpsps) begin
      acc_r[ax] <= sat32(acc_raw, amploa_pkg::ACC_MAX);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        lines_r[i] <= amploa_pkg::LINES_RST;
      end
    end else if (is_sl) begin
      lines_r[ax] <= clamp16(sl_lines, amploa_pkg::LINES_MAX);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        steps_r[i] <= amploa_pkg::STEPS_RST;
      end
    end else if (is_sl) begin
      steps_r[ax] <= clamp16(sl_steps, amploa_pkg::STEPS_MAX);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        tgt_r[i] <= 32'h0000_0000;
      end
    end else if (is_tgt) begin
      tgt_r[ax] <= data_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        tgt_rel_r[i] <= 1'h0;
      end
    end else if (is_tgt) begin
      tgt_rel_r[ax] <= rel_mode;
    end
  end

  // active destination taken when the start executes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        act_r[i] <= 32'h0000_0000;
      end
    end else if (is_start) begin
      act_r[ax] <= start_dest;
    end
  end

  // axis reached its destination: becomes the new stopped position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        pos_r[i] <= 32'h0000_0000;
      end
    end else if (is_stop) begin
      pos_r[ax] <= act_r[ax];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pulse <= 1'h0;
    end else begin
      start_pulse <= is_start;
    end
  end

  // axis and destination hold between starts so the motion side may sample late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_axis   <= 2'h0;
      start_target <= 32'h0000_0000;
    end else if (is_start) begin
      start_axis   <= ax;
      start_target <= start_dest;
    end
  end
endmodule // amploa_top
`default_nettype wire

/* File: hw/amploa_pkg.sv */
// How it works
// - velocity in rpm becomes steps per second or counts per sample period.
// - converted velocity saturates at the board maximum velocity.
// - servo acceleration becomes counts per sample period squared.
// - stepper acceleration becomes steps per second squared.
// - converted acceleration saturates at the board maximum acceleration.
// - lines from upper 16 bits, steps from lower 16 bits.
// - lines accepted 1 to 16383, reset value 200.
// - steps accepted 1 to 32767, reset value 200.
// - out-of-range steps or lines clamp to the limit, no error.
// - counts per revolution are four times lines per revolution.
// - open-loop board rejects steps-and-lines command with command error.
// - target position is a signed 32-bit value.
// - absolute mode target is the destination, moved to on start.
// - relative mode target is a distance from last stopped position.
// - loaded target buffered per axis, overwritten, applied on start.
`default_nettype none
package amploa_pkg;
  localparam int unsigned NAXIS          = 4;
  localparam logic [11:0] OFF_CMD_AXIS   = 12'h000;
  localparam logic [11:0] OFF_CMD_DATA   = 12'h004;
  localparam logic [11:0] OFF_CMD_GO     = 12'h008;
  localparam logic [11:0] OFF_STATUS     = 12'h00c;
  localparam logic [11:0] OFF_CONFIG     = 12'h010;
  localparam logic [11:0] OFF_RD_VEL     = 12'h014;
  localparam logic [11:0] OFF_RD_ACC     = 12'h018;
  localparam logic [11:0] OFF_RD_SL      = 12'h01c;
  localparam logic [11:0] OFF_RD_TGT     = 12'h020;
  localparam logic [11:0] OFF_RD_ACT     = 12'h024;
  localparam logic [11:0] OFF_RD_POS     = 12'h028;
  localparam logic [2:0]  CMD_RPM        = 3'h1;
  localparam logic [2:0]  CMD_RPSPS      = 3'h2;
  localparam logic [2:0]  CMD_STEPS_LINES = 3'h3;
  localparam logic [2:0]  CMD_TARGET     = 3'h4;
  localparam logic [2:0]  CMD_START      = 3'h5;
  localparam logic [2:0]  CMD_STOP       = 3'h6;
  localparam int unsigned SL_LINES_LSB   = 16;
  localparam logic [15:0] LINES_MAX      = 16'h3fff;
  localparam logic [15:0] STEPS_MAX      = 16'h7fff;
  localparam logic [15:0] LINES_RST      = 16'h00c8;
  localparam logic [15:0] STEPS_RST      = 16'h00c8;
  localparam logic [31:0] VEL_MAX        = 32'h003f_ffff;
  localparam logic [31:0] ACC_MAX        = 32'h000f_ffff;
  // servo sample period in microseconds
  localparam int unsigned SAMPLE_US      = 341;
  localparam int unsigned CFG_SERVO_BIT  = 0;
  localparam int unsigned CFG_CLOSED_BIT = 1;
  localparam int unsigned CFG_REL_BIT    = 2;
  localparam int unsigned ST_ERR_BIT     = 0;
endpackage : amploa_pkg
`default_nettype wire

/* File: verification/amploa_top_monitor.sv */
`default_nettype none
module amploa_top_monitor (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // motion side
  input wire logic        start_pulse,
  input wire logic [1:0]  start_axis,
  input wire logic [31:0] start_target
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire go_st = psel && penable && pwrite && paddr == amploa_pkg::OFF_CMD_GO && pwdata[2:0] == amploa_pkg::CMD_START;
  wire rd    = pready && !pwrite;
  ////////////////////////////////////////
  a_ready_next: assert property (psel && !penable |=> pready) else $error("setup not answered");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_start_go: assert property (go_st |=> start_pulse) else $error("start missing");
  a_start_cause: assert property (start_pulse |-> $past(go_st)) else $error("stray start");
  a_start_hold: assert property (!start_pulse |-> $stable(start_target) && $stable(start_axis))
    else $error("start outputs moved");
  a_vel_sat: assert property (rd && paddr == amploa_pkg::OFF_RD_VEL |-> prdata <= amploa_pkg::VEL_MAX)
    else $error("velocity over max");
  a_acc_sat: assert property (rd && paddr == amploa_pkg::OFF_RD_ACC |-> prdata <= amploa_pkg::ACC_MAX)
    else $error("accel over max");
  a_sl_range: assert property (rd && paddr == amploa_pkg::OFF_RD_SL |->
    prdata[31:16] inside {[1:amploa_pkg::LINES_MAX]} && prdata[15:0] inside {[1:amploa_pkg::STEPS_MAX]})
    else $error("steps or lines out of range");
  a_unmapped: assert property (rd && paddr > amploa_pkg::OFF_RD_POS |-> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
endmodule // amploa_top_monitor
bind amploa_top amploa_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .start_pulse(start_pulse), .start_axis(start_axis), .start_target(start_target));
`default_nettype wire

/* File: verification/amploa_axis_model.sv */
`default_nettype none
module amploa_axis_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // start from the loader
  input  wire logic        start_pulse,
  input  wire logic [1:0]  start_axis,
  input  wire logic [31:0] start_target,
  // what the axis saw
  output logic      [7:0]  seen_cnt,
  output logic      [1:0]  seen_axis,
  output logic      [31:0] seen_target
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////
  // move on start only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_cnt    <= 8'h00;
      seen_axis   <= 2'h0;
      seen_target <= 32'h0;
    end else if (start_pulse) begin
      seen_cnt    <= seen_cnt + 8'h01;
      seen_axis   <= start_axis;
      seen_target <= start_target;
    end
  end
endmodule // amploa_axis_model
`default_nettype wire

/* File: verification/axis_motion_parameter_loader_test.sv */
`default_nettype none
module axis_motion_parameter_loader_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdata, d, t;
  wire logic [31:0] prdata, start_target, mt;
  wire logic pready, pslverr, start_pulse;
  wire logic [1:0] start_axis, ma;
  wire logic [7:0] mc;
  logic [15:0] ln[4], st[4];
  int miscompares = 0, checked = 0, cyc = 0;
  always #50 pclk = ~pclk;
  amploa_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_pulse(start_pulse), .start_axis(start_axis), .start_target(start_target));
  amploa_axis_model u_axis (.pclk(pclk), .presetn(presetn), .start_pulse(start_pulse), .start_axis(start_axis),
    .start_target(start_target), .seen_cnt(mc), .seen_axis(ma), .seen_target(mt));
  ////////////////////////////////////////
  task close_out;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      close_out;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata; rerr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task cmd(input logic [1:0] ax, input logic [31:0] v, input logic [2:0] c);
    apb(1, amploa_pkg::OFF_CMD_AXIS, {30'h0, ax});
    apb(1, amploa_pkg::OFF_CMD_DATA, v);
    apb(1, amploa_pkg::OFF_CMD_GO, {29'h0, c});
  endtask
  task rd(input logic [1:0] ax, input logic [11:0] a);
    apb(1, amploa_pkg::OFF_CMD_AXIS, {30'h0, ax});
    apb(0, a, 32'h0);
  endtask
  function automatic logic [31:0] vexp(input logic [63:0] v, input logic sv, input logic [15:0] l, s);
    logic [63:0] r;
    r = (sv ? v * 4 * l * amploa_pkg::SAMPLE_US / 64'd60000000 : v * s / 60) >> 16;
    return r > amploa_pkg::VEL_MAX ? amploa_pkg::VEL_MAX : r[31:0];
  endfunction
  function automatic logic [31:0] aexp(input logic [95:0] v, input logic sv, input logic [15:0] l, s);
    logic [95:0] r;
    r = (sv ? v * 4 * l * amploa_pkg::SAMPLE_US * amploa_pkg::SAMPLE_US / 96'd1000000000000 : v * s) >> 16;
    return r > amploa_pkg::ACC_MAX ? amploa_pkg::ACC_MAX : r[31:0];
  endfunction
  initial begin
    void'($urandom(46));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    for (int a = 0; a < 4; a++) begin
      rd(a[1:0], amploa_pkg::OFF_RD_SL);
      chk(rdata, 32'h00c8_00c8);
    end
    // open-loop board refuses the packed word
    cmd(0, 32'h0010_0010, amploa_pkg::CMD_STEPS_LINES);
    apb(0, amploa_pkg::OFF_STATUS, 32'h0);
    chk(rdata[0], 1);
    rd(0, amploa_pkg::OFF_RD_SL);
    chk(rdata, 32'h00c8_00c8);
    apb(1, amploa_pkg::OFF_STATUS, 32'h1);
    apb(1, amploa_pkg::OFF_CONFIG, 32'h2);
    cmd(1, 32'hffff_0000, amploa_pkg::CMD_STEPS_LINES);
    rd(1, amploa_pkg::OFF_RD_SL);
    chk(rdata, 32'h3fff_0001);
    apb(0, amploa_pkg::OFF_STATUS, 32'h0);
    chk(rdata[0], 0);
    for (int a = 0; a < 4; a++) begin
      ln[a] = 16'(1 + $urandom % 16383);
      st[a] = 16'(1 + $urandom % 32767);
      d = $urandom & 32'h00ff_ffff;
      apb(1, amploa_pkg::OFF_CONFIG, {30'h0, 1'b1, a[0]});
      cmd(a[1:0], {ln[a], st[a]}, amploa_pkg::CMD_STEPS_LINES);
      cmd(a[1:0], d, amploa_pkg::CMD_RPM);
      rd(a[1:0], amploa_pkg::OFF_RD_VEL);
      chk(rdata, vexp(d, a[0], ln[a], st[a]));
      cmd(a[1:0], d, amploa_pkg::CMD_RPSPS);
      rd(a[1:0], amploa_pkg::OFF_RD_ACC);
      chk(rdata, aexp(d, a[0], ln[a], st[a]));
    end
    rd(0, amploa_pkg::OFF_RD_SL);
    chk(rdata, {ln[0], st[0]});
    apb(1, amploa_pkg::OFF_CONFIG, 32'h2);
    cmd(2, 32'h0000_7fff, amploa_pkg::CMD_STEPS_LINES);
    cmd(2, 32'hffff_ffff, amploa_pkg::CMD_RPM);
    cmd(2, 32'hffff_ffff, amploa_pkg::CMD_RPSPS);
    rd(2, amploa_pkg::OFF_RD_VEL);
    chk(rdata, amploa_pkg::VEL_MAX);
    rd(2, amploa_pkg::OFF_RD_ACC);
    chk(rdata, amploa_pkg::ACC_MAX);
    apb(1, amploa_pkg::OFF_CONFIG, 32'h3);
    cmd(2, 32'h3fff_7fff, amploa_pkg::CMD_STEPS_LINES);
    cmd(2, 32'hffff_ffff, amploa_pkg::CMD_RPSPS);
    rd(2, amploa_pkg::OFF_RD_ACC);
    chk(rdata, aexp(32'hffff_ffff, 1, 16'h3fff, 16'h7fff));
    apb(0, 12'h0fc, 32'h0);
    chk({rdata[30:0], rerr}, 32'h1);
    // later loads overwrite, start applies the last one
    t = $urandom;
    cmd(3, ~t, amploa_pkg::CMD_TARGET);
    cmd(3, t, amploa_pkg::CMD_TARGET);
    rd(3, amploa_pkg::OFF_RD_TGT);
    chk(rdata, t);
    cmd(3, 32'h0, amploa_pkg::CMD_START);
    repeat (3) @(posedge pclk);
    chk({mc, 22'h0, ma}, {8'h01, 24'h3});
    chk(mt, t);
    cmd(3, 32'h0, amploa_pkg::CMD_STOP);
    apb(1, amploa_pkg::OFF_CONFIG, 32'h6);
    d = -($urandom % 32'h0010_0000);
    cmd(3, d, amploa_pkg::CMD_TARGET);
    cmd(3, 32'h0, amploa_pkg::CMD_START);
    repeat (3) @(posedge pclk);
    chk(mt, t + d);
    close_out;
  end
endmodule // axis_motion_parameter_loader_test
`default_nettype wire
